// ==== logic/sps_sampler.sv ====
// Purpose: quadrature tracking and reading trigger for a line-scan profile
// Assumes: encoder inputs synchronous-ish, double-flopped anyway; apb slave, zero wait
// Notes: settings edited in a pending copy, committed by done, dropped by cancel
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sps_map.svh"

// Summary of operation
// - bi-directional mode counts position both ways
// - uni-directional mode tracks forward movement only
// - manual mode triggers at 1..60 per second
// - manual mode ignores encoder, no position
// - pitch setting defaults to 50 pulses/inch
// - one reading every N pulses, N>=1
// - direction bit picks display fill order
// - mode step cycles bi, uni, manual
// - done commits edits, cancel discards them
module sps_sampler #(
    parameter int SEC_CYC = `SPS_SEC_CYC // cycles per second, shortened in simulation
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic enc_a,
    input wire logic enc_b,
    output logic sample_pulse,
    output logic [31:0] sample_pos,
    output logic sample_pos_valid,
    output logic fill_rtl,
    output sps_pkg::sps_cfg_t active_cfg
);
    import sps_pkg::*;

    // apb access strobes, zero wait states
    logic acc;
    logic wr;
    logic known;
    assign acc = psel && penable;
    assign wr = acc && pwrite && clk_en;
    assign pready = 1'b1;
    // unmapped offsets answer with an error
    always_comb begin
        unique case (paddr)
            `SPS_CTRL_OFF, `SPS_PEND_OFF, `SPS_ACT_OFF,
            `SPS_STAT_OFF, `SPS_POS_OFF, `SPS_CNT_OFF: known = 1'b1;
            default: known = 1'b0;
        endcase
    end
    assign pslverr = acc && !known;

    // encoder synchronisers and previous phase
    logic [1:0] a_q, b_q;
    logic [1:0] ab_prev_q;
    logic [1:0] ab_now;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_q <= 2'b00;
            b_q <= 2'b00;
            ab_prev_q <= 2'b00;
        end else if (clk_en) begin
            a_q <= {a_q[0], enc_a};
            b_q <= {b_q[0], enc_b};
            ab_prev_q <= ab_now;
        end
    end
    assign ab_now = {a_q[1], b_q[1]};

    // quadrature step decode, one count per full cycle at edge 00->01 / 00->10
    logic fwd;
    logic bwd;
    always_comb begin
        fwd = 1'b0;
        bwd = 1'b0;
        if (ab_prev_q == 2'b00 && ab_now == 2'b10) begin
            fwd = 1'b1;
        end else if (ab_prev_q == 2'b00 && ab_now == 2'b01) begin
            bwd = 1'b1;
        end
    end

    // settings: pending edit copy, active copy, edit cursor, run flag
    sps_cfg_t pend_q, pend_d;
    sps_cfg_t act_q, act_d;
    logic [1:0] field_q, field_d;
    logic run_q, run_d;
    logic [7:0] every_in;
    logic [7:0] rate_in;
    logic [1:0] mode_in;
    assign every_in = pwdata[`SPS_EVERY_LSB +: 8];
    assign rate_in = pwdata[`SPS_RATE_LSB +: 8];
    assign mode_in = pwdata[`SPS_MODE_LSB +: 2];

    // next settings
    always_comb begin
        pend_d = pend_q;
        act_d = act_q;
        field_d = field_q;
        run_d = run_q;
        if (wr && paddr == `SPS_PEND_OFF) begin
            // illegal mode code keeps the old mode
            if (mode_in != 2'b11) begin
                pend_d.mode = sps_mode_t'(mode_in);
            end
            pend_d.dir_rtl = pwdata[`SPS_DIR_BIT];
            pend_d.pitch = pwdata[`SPS_PITCH_LSB +: 8];
            pend_d.every = (every_in == 8'h00) ? 8'h01 : every_in;
            if (rate_in < 8'(`SPS_RATE_MIN)) begin
                pend_d.rate = 8'(`SPS_RATE_MIN);
            end else if (rate_in > 8'(`SPS_RATE_MAX)) begin
                pend_d.rate = 8'(`SPS_RATE_MAX);
            end else begin
                pend_d.rate = rate_in;
            end
        end else if (wr && paddr == `SPS_CTRL_OFF) begin
            if (pwdata[`SPS_MSTEP_BIT]) begin
                unique case (pend_q.mode)
                    SPS_BIDIR: pend_d.mode = SPS_UNIDIR;
                    SPS_UNIDIR: pend_d.mode = SPS_MANUAL;
                    default: pend_d.mode = SPS_BIDIR;
                endcase
                field_d = 2'b00;
            end
            if (pwdata[`SPS_FADV_BIT]) begin
                unique case (pend_q.mode)
                    SPS_BIDIR: field_d = (field_q == 2'b00) ? 2'b01 : 2'b00;
                    SPS_UNIDIR: field_d = (field_q == 2'b10) ? 2'b00 : field_q + 2'b01;
                    default: field_d = (field_q == 2'b00) ? 2'b10 : 2'b00;
                endcase
            end
            if (pwdata[`SPS_DONE_BIT]) begin
                act_d = pend_q;
                field_d = 2'b00;
            end else if (pwdata[`SPS_CANCEL_BIT]) begin
                pend_d = act_q;
                field_d = 2'b00;
            end
            run_d = pwdata[`SPS_RUN_BIT];
        end
    end

    // settings registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= '{rate: `SPS_RATE_RST, every: `SPS_EVERY_RST, pitch: `SPS_PITCH_RST,
                        dir_rtl: 1'b0, mode: SPS_BIDIR};
            act_q <= '{rate: `SPS_RATE_RST, every: `SPS_EVERY_RST, pitch: `SPS_PITCH_RST,
                       dir_rtl: 1'b0, mode: SPS_BIDIR};
            field_q <= 2'b00;
            run_q <= 1'b0;
        end else if (clk_en) begin
            pend_q <= pend_d;
            act_q <= act_d;
            field_q <= field_d;
            run_q <= run_d;
        end
    end

    // tracking: position, interval count, manual timer, trigger
    logic [31:0] pos_q, pos_d;
    logic [7:0] ivl_q, ivl_d;
    logic [31:0] tmr_q, tmr_d;
    logic [31:0] tmr_top;
    logic trig_q, trig_d;
    logic [31:0] cnt_q, cnt_d;
    logic posv_q, posv_d;
    // manual period: one second divided by rate, rounded down
    assign tmr_top = 32'(SEC_CYC) / {24'h000000, act_q.rate};

    // next tracking state
    always_comb begin
        pos_d = pos_q;
        ivl_d = ivl_q;
        tmr_d = tmr_q;
        trig_d = 1'b0;
        cnt_d = cnt_q;
        posv_d = posv_q;
        unique case (act_q.mode)
            SPS_BIDIR: begin
                if (fwd) begin
                    pos_d = pos_q + 32'h00000001;
                end else if (bwd) begin
                    pos_d = pos_q - 32'h00000001;
                end
                if (run_q && (fwd || bwd)) begin
                    if (ivl_q + 8'h01 >= act_q.every) begin
                        ivl_d = 8'h00;
                        trig_d = 1'b1;
                        posv_d = 1'b1;
                    end else begin
                        ivl_d = ivl_q + 8'h01;
                    end
                end
            end
            SPS_UNIDIR: begin
                if (fwd) begin
                    pos_d = pos_q + 32'h00000001;
                    if (run_q) begin
                        if (ivl_q + 8'h01 >= act_q.every) begin
                            ivl_d = 8'h00;
                            trig_d = 1'b1;
                            posv_d = 1'b1;
                        end else begin
                            ivl_d = ivl_q + 8'h01;
                        end
                    end
                end
            end
            default: begin
                posv_d = 1'b0;
                if (!run_q) begin
                    tmr_d = 32'h00000000;
                end else if (tmr_q + 32'h00000001 >= tmr_top) begin
                    tmr_d = 32'h00000000;
                    trig_d = 1'b1;
                end else begin
                    tmr_d = tmr_q + 32'h00000001;
                end
            end
        endcase
        if (wr && paddr == `SPS_CTRL_OFF && pwdata[`SPS_CLRPOS_BIT]) begin
            pos_d = 32'h00000000;
            ivl_d = 8'h00;
            cnt_d = 32'h00000000;
        end else if (trig_d) begin
            cnt_d = cnt_q + 32'h00000001;
        end
        // new settings restart interval and timer
        if (wr && paddr == `SPS_CTRL_OFF && pwdata[`SPS_DONE_BIT]) begin
            ivl_d = 8'h00;
            tmr_d = 32'h00000000;
        end
    end

    // tracking registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_q <= 32'h00000000;
            ivl_q <= 8'h00;
            tmr_q <= 32'h00000000;
            trig_q <= 1'b0;
            cnt_q <= 32'h00000000;
            posv_q <= 1'b0;
        end else if (clk_en) begin
            pos_q <= pos_d;
            ivl_q <= ivl_d;
            tmr_q <= tmr_d;
            trig_q <= trig_d;
            cnt_q <= cnt_d;
            posv_q <= posv_d;
        end
    end

    // outputs
    assign sample_pulse = trig_q;
    assign sample_pos = posv_q ? pos_q : 32'h00000000;
    assign sample_pos_valid = posv_q;
    assign fill_rtl = act_q.dir_rtl;
    assign active_cfg = act_q;

    // read mux, combinational
    always_comb begin
        prdata = 32'h00000000;
        if (acc && !pwrite) begin
            unique case (paddr)
                `SPS_CTRL_OFF: prdata = {27'h0000000, run_q, 4'h0};
                `SPS_PEND_OFF: prdata = {pend_q.rate, pend_q.every, pend_q.pitch,
                                         5'h00, pend_q.dir_rtl, pend_q.mode};
                `SPS_ACT_OFF: prdata = {act_q.rate, act_q.every, act_q.pitch,
                                        5'h00, act_q.dir_rtl, act_q.mode};
                `SPS_STAT_OFF: prdata = {22'h000000, field_q, ivl_q};
                `SPS_POS_OFF: prdata = pos_q;
                `SPS_CNT_OFF: prdata = cnt_q;
                default: prdata = 32'h00000000;
            endcase
        end
    end
endmodule : sps_sampler
`default_nettype wire

// ==== logic/sps_map.svh ====
// Purpose: register offsets, reset values and timing counts for the scan position sampler
// Assumes: apb with 32-bit data, one aligned word per register
// Notes: definitions only
`ifndef SPS_MAP_SVH
`define SPS_MAP_SVH
// register byte offsets
`define SPS_CTRL_OFF 12'h000
`define SPS_PEND_OFF 12'h004
`define SPS_ACT_OFF 12'h008
`define SPS_STAT_OFF 12'h00C
`define SPS_POS_OFF 12'h010
`define SPS_CNT_OFF 12'h014
// pending word field positions
`define SPS_MODE_LSB 0
`define SPS_DIR_BIT 2
`define SPS_PITCH_LSB 8
`define SPS_EVERY_LSB 16
`define SPS_RATE_LSB 24
// control word bits (write one to act; the run bit takes the written value)
`define SPS_DONE_BIT 0
`define SPS_MSTEP_BIT 1
`define SPS_CANCEL_BIT 2
`define SPS_FADV_BIT 3
`define SPS_RUN_BIT 4
`define SPS_CLRPOS_BIT 5
// reset values
`define SPS_PITCH_RST 8'h32
`define SPS_EVERY_RST 8'h01
`define SPS_RATE_RST 8'h01
// timing: one second at the clock rate
`define SPS_SEC_NS 1000000000
`define SPS_CLK_NS 10
`define SPS_SEC_CYC (`SPS_SEC_NS / `SPS_CLK_NS)
`define SPS_RATE_MIN 1
`define SPS_RATE_MAX 60
`endif

// ==== logic/sps_pkg.sv ====
// Purpose: types shared by the scan position sampler
// Assumes: none
// Notes: settings travel as one packed struct
package sps_pkg;
    // scan mode encodings
    typedef enum logic [1:0] {
        SPS_BIDIR = 2'b00,
        SPS_UNIDIR = 2'b01,
        SPS_MANUAL = 2'b10
    } sps_mode_t;
    // one committed or pending setup set
    typedef struct packed {
        logic [7:0] rate;
        logic [7:0] every;
        logic [7:0] pitch;
        logic dir_rtl;
        sps_mode_t mode;
    } sps_cfg_t;
endpackage : sps_pkg

// ==== dv/sps_chk.sv ====
// Purpose: port checks for the scan position sampler
// Assumes: one clock, async active-low reset
// Notes: bound into every sampler instance
`timescale 1ns/1ps
`default_nettype none
module sps_chk import sps_pkg::*; #(
    parameter int SEC_CYC = 600 // manual period is SEC_CYC/rate
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sample_pulse,
    input wire logic [31:0] sample_pos,
    input wire logic sample_pos_valid,
    input wire logic fill_rtl,
    input wire sps_cfg_t active_cfg
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // zero-wait slave, errors only in access
    ready_high_a: assert property (pready) else $error("pready low");
    err_access_a: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
    rdata_idle_a: assert property (!(psel && penable) |-> prdata == 32'h0) else $error("prdata");
    cfg_commit_a: assert property (
        !$stable(active_cfg) |-> $past(psel && penable && pwrite))
        else $error("cfg changed without write");
    rate_range_a: assert property (active_cfg.rate >= 8'h01 && active_cfg.rate <= 8'h3C)
        else $error("rate range");
    every_min_a: assert property (active_cfg.every != 8'h00) else $error("every zero");
    mode_legal_a: assert property (active_cfg.mode != 2'b11) else $error("mode code");
    manual_nopos_a: assert property (active_cfg.mode == SPS_MANUAL [*2]
        |-> !sample_pos_valid && sample_pos == 32'h0) else $error("manual position");
    manual_gap_a: assert property (sample_pulse && active_cfg.mode == SPS_MANUAL
        |=> !sample_pulse [*8]) else $error("manual too fast");
    fill_dir_a: assert property (
        (active_cfg.mode != SPS_BIDIR && $stable(active_cfg)) [*2]
        |-> fill_rtl == active_cfg.dir_rtl) else $error("fill order");
    rst_cfg_a: assert property ($rose(presetn)
        |-> active_cfg.pitch == 8'h32 && active_cfg.every == 8'h01) else $error("reset cfg");
    cover property (sample_pulse && active_cfg.mode == SPS_BIDIR);
    cover property (sample_pulse && active_cfg.mode == SPS_UNIDIR);
    cover property (sample_pulse && active_cfg.mode == SPS_MANUAL);
endmodule : sps_chk
bind sps_sampler sps_chk #(.SEC_CYC(SEC_CYC)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_pulse(sample_pulse), .sample_pos(sample_pos),
    .sample_pos_valid(sample_pos_valid), .fill_rtl(fill_rtl), .active_cfg(active_cfg));
`default_nettype wire

// ==== dv/sps_enc_model.sv ====
// Purpose: quadrature encoder of the scanner
// Assumes: req held one cycle while idle
// Notes: lines rest at 00 between moves
`timescale 1ns/1ps
`default_nettype none
module sps_enc_model #(
    parameter int HOLD = 3 // cycles per phase
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] req, // 01 forward, 10 backward
    output logic enc_a,
    output logic enc_b,
    output logic busy
);
    logic [1:0] ph; // quarter of the cycle
    logic back; // direction of this move
    int cnt; // cycles in this phase
    // one full quadrature cycle per request
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0; ph <= 2'd0; cnt <= 0; back <= 1'b0;
        end else if (!busy) begin
            if (req != 2'b00) begin
                busy <= 1'b1; back <= req[1]; ph <= 2'd0; cnt <= 0;
            end
        end else if (cnt == HOLD - 1) begin
            cnt <= 0; ph <= ph + 2'd1;
            if (ph == 2'd3) busy <= 1'b0;
        end else cnt <= cnt + 1;
    end
    // two-phase gray order, a leads b going forward
    always_comb begin
        case (ph)
            2'd0: {enc_a, enc_b} = back ? 2'b01 : 2'b10;
            2'd1: {enc_a, enc_b} = 2'b11;
            2'd2: {enc_a, enc_b} = back ? 2'b10 : 2'b01;
            default: {enc_a, enc_b} = 2'b00;
        endcase
        if (!busy) {enc_a, enc_b} = 2'b00;
    end
endmodule : sps_enc_model
`default_nettype wire

// ==== dv/sps_sampler_tb_top.sv ====
// Purpose: self-checking bench for the scan position sampler
// Assumes: SEC_CYC 600, so 60 per second is a 10-cycle period
// Notes: control writes always carry the run bit
`timescale 1ns/1ps
`default_nettype none
`include "sps_map.svh"
module sps_sampler_tb_top;
    import sps_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, enc_a, enc_b, sample_pulse, sample_pos_valid;
    logic fill_rtl, busy, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat, sample_pos;
    logic [1:0] req = 2'b00;
    sps_cfg_t active_cfg;
    int n_errors = 0, checks_done = 0, n_pulse = 0, b;
    always #5 pclk = ~pclk;
    // reading triggers seen at the port
    always @(posedge pclk) if (sample_pulse === 1'b1) n_pulse <= n_pulse + 1;
    sps_sampler #(.SEC_CYC(600)) u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b),
        .sample_pulse(sample_pulse), .sample_pos(sample_pos),
        .sample_pos_valid(sample_pos_valid), .fill_rtl(fill_rtl), .active_cfg(active_cfg));
    sps_enc_model #(.HOLD(3)) u_enc (.pclk(pclk), .presetn(presetn), .req(req),
        .enc_a(enc_a), .enc_b(enc_b), .busy(busy));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // apb setup then access, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // wait as long as the slave wants; only the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic move(input logic [1:0] d, input int n);
        repeat (n) begin
            @(posedge pclk); req <= d;
            @(posedge pclk); req <= 2'b00;
            do begin
                @(posedge pclk);
            end while (busy !== 1'b0);
        end
        repeat (6) @(posedge pclk);
    endtask : move
    task automatic pulses(input int n);
        chk(32'(n_pulse - b), 32'(n));
    endtask : pulses
    task automatic t_reset;
        apb(1'b0, `SPS_ACT_OFF, 32'h0);
        chk(rdat, 32'h0101_3200);
        chk({24'h0, active_cfg.pitch}, 32'h32);
        $display("reset test over");
    endtask : t_reset
    task automatic t_bidir;
        apb(1'b1, `SPS_CTRL_OFF, 32'h30);
        b = n_pulse;
        move(2'b01, 3);
        pulses(3);
        apb(1'b0, `SPS_POS_OFF, 32'h0);
        chk(rdat, 32'h3);
        move(2'b10, 1);
        apb(1'b0, `SPS_POS_OFF, 32'h0);
        chk(rdat, 32'h2);
        chk({31'h0, sample_pos_valid}, 32'h1);
        chk(sample_pos, 32'h2);
        // three forward and one backward reading since the clear
        apb(1'b0, `SPS_CNT_OFF, 32'h0);
        chk(rdat, 32'h4);
        $display("bidir test over");
    endtask : t_bidir
    task automatic t_every;
        apb(1'b1, `SPS_PEND_OFF, 32'h0103_3200);
        apb(1'b1, `SPS_CTRL_OFF, 32'h11);
        b = n_pulse;
        move(2'b01, 2);
        pulses(0);
        move(2'b01, 1);
        pulses(1);
        move(2'b01, 2);
        pulses(1);
        $display("interval test over");
    endtask : t_every
    task automatic t_uni;
        apb(1'b1, `SPS_PEND_OFF, 32'h0101_3205);
        apb(1'b1, `SPS_CTRL_OFF, 32'h11);
        apb(1'b0, `SPS_ACT_OFF, 32'h0);
        chk(rdat, 32'h0101_3205);
        chk({31'h0, fill_rtl}, 32'h1);
        // uni cursor walks pitch, interval, direction
        apb(1'b1, `SPS_CTRL_OFF, 32'h18);
        apb(1'b1, `SPS_CTRL_OFF, 32'h18);
        apb(1'b0, `SPS_STAT_OFF, 32'h0);
        chk({30'h0, rdat[9:8]}, 32'h2);
        b = n_pulse;
        move(2'b10, 2);
        pulses(0);
        move(2'b01, 1);
        pulses(1);
        $display("uni test over");
    endtask : t_uni
    task automatic t_cancel;
        apb(1'b1, `SPS_PEND_OFF, 32'h0105_3200);
        apb(1'b1, `SPS_CTRL_OFF, 32'h14);
        apb(1'b0, `SPS_ACT_OFF, 32'h0);
        chk(rdat, 32'h0101_3205);
        // the pending copy falls back to the committed one
        apb(1'b0, `SPS_PEND_OFF, 32'h0);
        chk(rdat, 32'h0101_3205);
        apb(1'b1, `SPS_CTRL_OFF, 32'h12);
        apb(1'b0, `SPS_PEND_OFF, 32'h0);
        chk({30'h0, rdat[1:0]}, 32'h2);
        apb(1'b1, `SPS_CTRL_OFF, 32'h12);
        apb(1'b0, `SPS_PEND_OFF, 32'h0);
        chk({30'h0, rdat[1:0]}, 32'h0);
        // mode code 3 is refused, the rest of the word lands
        apb(1'b1, `SPS_PEND_OFF, 32'h0107_3207);
        apb(1'b0, `SPS_PEND_OFF, 32'h0);
        chk(rdat, 32'h0107_3204);
        // a write while the clock enable is low is lost
        clk_en <= 1'b0;
        apb(1'b1, `SPS_PEND_OFF, 32'h0101_3201);
        clk_en <= 1'b1;
        apb(1'b0, `SPS_PEND_OFF, 32'h0);
        chk(rdat, 32'h0107_3204);
        $display("cancel test over");
    endtask : t_cancel
    task automatic t_manual;
        apb(1'b1, `SPS_PEND_OFF, 32'h5000_3202);
        apb(1'b0, `SPS_PEND_OFF, 32'h0);
        chk(rdat, 32'h3C01_3202);
        apb(1'b1, `SPS_CTRL_OFF, 32'h11);
        b = n_pulse;
        repeat (200) @(posedge pclk);
        chk({31'h0, (n_pulse - b) inside {[19:21]}}, 32'h1);
        move(2'b01, 2);
        chk(sample_pos, 32'h0);
        chk({31'h0, sample_pos_valid}, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("manual test over");
    endtask : t_manual
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset(); t_bidir(); t_every(); t_uni(); t_cancel(); t_manual();
        summarize();
    end
    // hang guard, well past the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        summarize();
    end
endmodule : sps_sampler_tb_top
`default_nettype wire
